/* ctl_model.sv */
// two-wire serial controller model that issues register reads and writes
// assumes the bench resolves the open-drain data wire and feeds it back on i_sda
`timescale 1ns/1ps
module ctl_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // data moves only while scl is low, so no false start or stop is seen
   task automatic bit_io(input logic b, output logic r);
      o_sda_low = !b;
      tick(4);
      o_scl = 1'b1;
      tick(4);
      r = i_sda;
      o_scl = 1'b0;
      tick(2);
   endtask : bit_io
   task automatic start;
      o_sda_low = 1'b0;
      tick(2);
      o_scl = 1'b1;
      tick(4);
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b0;
      tick(2);
   endtask : start
   task automatic stop;
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b1;
      tick(4);
      o_sda_low = 1'b0;
      tick(4);
   endtask : stop
   task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                          output logic a_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(a_in, a_out);
   endtask : byte_io
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic       k0;
      logic       k1;
      logic       k2;
      start();
      byte_io({7'h4C, 1'b0}, 1'b1, q, k0);
      byte_io(a, 1'b1, q, k1);
      byte_io(d, 1'b1, q, k2);
      stop();
      nak = k0 | k1 | k2;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
      logic [7:0] x;
      logic       k;
      start();
      byte_io({7'h4C, 1'b0}, 1'b1, x, k);
      byte_io(a, 1'b1, x, k);
      start();
      byte_io({7'h4C, 1'b1}, 1'b1, x, k);
      byte_io(8'hFF, 1'b1, q, k);
      stop();
   endtask : rd_reg
endmodule : ctl_model

/* serial_reg_port.sv */
// two-wire serial slave: pointer write, byte writes and auto-increment reads
// assumes scl and sda arrive synchronous to the pixel clock; no clock stretching
`timescale 1ns/1ps
module serial_reg_port
   import sync_front_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h4C
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_raddr,
   output logic      [7:0] o_waddr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_sda_oe
);
   port_state_e st_reg, st_next;
   logic       scl_reg, sda_reg, oe_reg, oe_next, nack_reg, nack_next, wr_reg, wr_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, waddr_reg, waddr_next, wdata_reg, wdata_next;
   logic       rise, fall, start, stop;

   assign rise  = i_scl & ~scl_reg;
   assign fall  = ~i_scl & scl_reg;
   assign start = i_scl & scl_reg & sda_reg & ~i_sda;
   assign stop  = i_scl & scl_reg & ~sda_reg & i_sda;

   always_comb begin
      st_next = st_reg; cnt_next = cnt_reg; sh_next = sh_reg; ptr_next = ptr_reg;
      oe_next = oe_reg; nack_next = nack_reg; wr_next = 1'b0;
      waddr_next = waddr_reg; wdata_next = wdata_reg;
      if (start) begin
         st_next = SP_DEV; cnt_next = 4'h0; oe_next = 1'b0;
      end else if (stop) begin
         st_next = SP_IDLE; oe_next = 1'b0;
      end else if (st_reg != SP_IDLE) begin
         if (rise) begin
            if (cnt_reg < 4'h8) begin
               if (st_reg != SP_RD) sh_next = {sh_reg[6:0], i_sda};
               cnt_next = cnt_reg + 4'h1;
            end else if (cnt_reg == 4'h9 && st_reg == SP_RD) begin
               nack_next = i_sda;
            end
         end
         if (fall) begin
            if (cnt_reg == 4'h8) begin
               cnt_next = 4'h9;
               unique case (st_reg)
                  SP_DEV: begin
                     if (sh_reg[7:1] == DEV_ADDR) begin
                        oe_next = 1'b1; nack_next = 1'b0;
                     end else begin
                        st_next = SP_IDLE;
                     end
                  end
                  SP_PTR: begin ptr_next = sh_reg; oe_next = 1'b1; end
                  SP_WR: begin
                     wr_next = 1'b1; waddr_next = ptr_reg; wdata_next = sh_reg;
                     ptr_next = ptr_reg + 8'h01; oe_next = 1'b1;
                  end
                  SP_RD: oe_next = 1'b0;
                  SP_IDLE: ;
               endcase
            end else if (cnt_reg == 4'h9) begin
               cnt_next = 4'h0; oe_next = 1'b0;
               if (st_reg == SP_DEV) st_next = sh_reg[0] ? SP_RD : SP_PTR;
               else if (st_reg == SP_PTR) st_next = SP_WR;
               if (st_next == SP_RD) begin
                  if (nack_reg) begin
                     st_next = SP_IDLE;
                  end else begin
                     sh_next = i_rdata; ptr_next = ptr_reg + 8'h01; oe_next = ~i_rdata[7];
                  end
               end
            end else if (st_reg == SP_RD && cnt_reg != 4'h0) begin
               oe_next = ~sh_reg[3'(4'h7 - cnt_reg)];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= SP_IDLE; cnt_reg <= 4'h0; sh_reg <= 8'h00; ptr_reg <= 8'h00;
         scl_reg <= 1'b1; sda_reg <= 1'b1; oe_reg <= 1'b0; nack_reg <= 1'b0;
         wr_reg <= 1'b0; waddr_reg <= 8'h00; wdata_reg <= 8'h00;
      end else begin
         st_reg <= st_next; cnt_reg <= cnt_next; sh_reg <= sh_next; ptr_reg <= ptr_next;
         scl_reg <= i_scl; sda_reg <= i_sda; oe_reg <= oe_next; nack_reg <= nack_next;
         wr_reg <= wr_next; waddr_reg <= waddr_next; wdata_reg <= wdata_next;
      end
   end

   assign o_raddr  = ptr_reg;
   assign o_waddr  = waddr_reg;
   assign o_wdata  = wdata_reg;
   assign o_wr     = wr_reg;
   assign o_sda_oe = oe_reg;

endmodule : serial_reg_port

/* sync_coast_clamp_control.sv */
// sync processing front end: source and polarity choice, regenerated syncs,
// frame filter, coast window and clamp source, under serial register control
// assumes all sync inputs are synchronous to the pixel clock
`timescale 1ns/1ps
module sync_coast_clamp_control #(
   parameter logic [6:0] DEV_ADDR    = sync_front_pkg::DEV_ADDR_DEF,
   parameter int         ACT_TIMEOUT = sync_front_pkg::ACT_TIMEOUT_DEF
) (
   input  wire logic I_CORE_CLK,
   input  wire logic I_RST_N,
   input  wire logic I_SCL,
   input  wire logic I_SDA_IN,
   output logic      O_SDA_OUT,
   output logic      O_SDA_OE,
   input  wire logic I_LINE_SYNC_INPUT_PINS,
   input  wire logic I_GREEN_EMBEDDED_SYNC,
   input  wire logic I_FRAME_SYNC_INPUT_PINS,
   input  wire logic I_FRAME_SEP_SYNC,
   input  wire logic I_EXT_COAST,
   input  wire logic I_EXT_CLAMP,
   output logic      O_LINE_SYNC_OUTPUT,
   output logic      O_FRAME_SYNC_OUTPUT,
   output logic      O_PLL_LINE_REF,
   output logic      O_COAST,
   output logic      O_CLAMP,
   output logic      O_LINE_SRC_GREEN,
   output logic      O_FRAME_SRC_SEP
);
   import sync_front_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register port and register file

   logic [7:0]  raddr, waddr, wdata, rdata;
   logic        wr;
   logic [7:0]  regs_reg [N_REGS];
   logic [7:0]  regs_next [N_REGS];
   line_ctrl_s  hctl;
   frame_ctrl_s vctl;
   hold_ctrl_s  hold;

   function automatic logic in_map(input logic [7:0] a);
      return (a >= ADDR_HCTL) && (a <= ADDR_HOLD);
   endfunction : in_map

   serial_reg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
      .i_clk    (I_CORE_CLK),
      .i_rst_n  (I_RST_N),
      .i_scl    (I_SCL),
      .i_sda    (I_SDA_IN),
      .i_rdata  (rdata),
      .o_raddr  (raddr),
      .o_waddr  (waddr),
      .o_wdata  (wdata),
      .o_wr     (wr),
      .o_sda_oe (O_SDA_OE)
   );

   always_comb begin
      regs_next = regs_reg;
      if (wr && in_map(waddr)) begin
         regs_next[3'(waddr - ADDR_HCTL)] = wdata;
      end
      // unmapped bytes read back as zero, writes to them are dropped
      rdata = in_map(raddr) ? regs_reg[3'(raddr - ADDR_HCTL)] : RD_UNMAPPED;
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         regs_reg  <= RST_VAL;
         O_SDA_OUT <= 1'b0;
      end else begin
         regs_reg  <= regs_next;
         O_SDA_OUT <= 1'b0;
      end
   end

   assign hctl = line_ctrl_s'(regs_reg[IDX_HCTL]);
   assign vctl = frame_ctrl_s'(regs_reg[IDX_VCTL]);
   assign hold = hold_ctrl_s'(regs_reg[IDX_HOLD]);

   ////////////////////////////////////////////////////////////////////////////
   // activity and polarity sense of every sync input

   logic [N_SENSE-1:0] raw, act, pos;

   assign raw = {I_EXT_COAST, I_FRAME_SEP_SYNC, I_FRAME_SYNC_INPUT_PINS,
                 I_GREEN_EMBEDDED_SYNC, I_LINE_SYNC_INPUT_PINS};

   for (genvar g = 0; g < N_SENSE; g++) begin : g_sense
      sync_sense #(.TIMEOUT(ACT_TIMEOUT), .CW(SENSE_W)) u_sense (
         .i_clk    (I_CORE_CLK),
         .i_rst_n  (I_RST_N),
         .i_sync   (raw[g]),
         .o_active (act[g]),
         .o_pos    (pos[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // source choice and polarity normalisation

   logic line_green, line_pos, hs_norm;
   logic frame_sep, frame_pos, vs_norm;
   logic coast_pos, coast_ext;

   always_comb begin
      if (hctl.src_ovr) begin
         line_green = hctl.src_sel;
      end else if (act[SN_LINE_PIN] && act[SN_GREEN]) begin
         line_green = hctl.src_sel;
      end else begin
         line_green = act[SN_GREEN];
      end
      line_pos = hctl.pol_ovr ? hctl.pol
                              : pos[line_green ? SN_GREEN : SN_LINE_PIN];
      hs_norm  = raw[line_green ? SN_GREEN : SN_LINE_PIN] ~^ line_pos;
      frame_sep = vctl.src_ovr ? vctl.src_sel : !act[SN_FRAME_PIN];
      frame_pos = vctl.pol_ovr ? vctl.pol
                               : pos[frame_sep ? SN_FRAME_SEP : SN_FRAME_PIN];
      vs_norm   = raw[frame_sep ? SN_FRAME_SEP : SN_FRAME_PIN] ~^ frame_pos;
      coast_pos = hold.coast_pol_ovr ? hold.coast_pol : pos[SN_COAST];
      coast_ext = raw[SN_COAST] ~^ coast_pos;
   end

   ////////////////////////////////////////////////////////////////////////////
   // regenerated syncs, frame filter and coast window

   logic              hs_norm_reg, vs_filt_reg, vs_filt_next, vs_src, vs_src_reg;
   logic              hs_lead, vs_lead, vs_trail;
   logic [7:0]        hs_cnt_reg, hs_cnt_next, vd_cnt_reg, vd_cnt_next;
   logic [7:0]        post_cnt_reg, post_cnt_next;
   logic [LINE_W-1:0] line_cnt_reg, line_cnt_next, frame_lines_reg, frame_lines_next;
   logic              pre_hit, vs_act_next, coast_int, coast_next, clamp_next;

   assign hs_lead  = hs_norm & ~hs_norm_reg;
   // the filter only lets the frame sync change at line sync leading edges
   assign vs_src   = vctl.filt_en ? vs_filt_reg : vs_norm;
   assign vs_lead  = vs_src & ~vs_src_reg;
   assign vs_trail = ~vs_src & vs_src_reg;

   always_comb begin
      hs_cnt_next      = hs_cnt_reg;
      vd_cnt_next      = vd_cnt_reg;
      post_cnt_next    = post_cnt_reg;
      line_cnt_next    = line_cnt_reg;
      frame_lines_next = frame_lines_reg;
      vs_filt_next     = hs_lead ? vs_norm : vs_filt_reg;
      if (hs_lead) begin
         hs_cnt_next = regs_reg[IDX_HWID];
      end else if (hs_cnt_reg != 8'h00) begin
         hs_cnt_next = hs_cnt_reg - 8'h01;
      end
      if (vs_lead) begin
         vd_cnt_next = regs_reg[IDX_VWID];
      end else if (hs_lead && vd_cnt_reg != 8'h00) begin
         vd_cnt_next = vd_cnt_reg - 8'h01;
      end
      vs_act_next = vctl.dur_en ? (vd_cnt_next != 8'h00) : vs_src;
      // line count per frame predicts where the next frame sync lands
      if (vs_lead) begin
         frame_lines_next = line_cnt_reg;
         line_cnt_next    = '0;
      end else if (hs_lead && line_cnt_reg != '1) begin
         line_cnt_next = line_cnt_reg + 1'b1;
      end
      if (vs_trail) begin
         post_cnt_next = regs_reg[IDX_POST];
      end else if (hs_lead && post_cnt_reg != 8'h00) begin
         post_cnt_next = post_cnt_reg - 8'h01;
      end
      pre_hit = (frame_lines_reg != '0) && (regs_reg[IDX_PRE] != 8'h00) &&
                (({1'b0, line_cnt_reg} + (LINE_W + 1)'(regs_reg[IDX_PRE])) >=
                 {1'b0, frame_lines_reg});
      coast_int  = pre_hit | vs_src | (post_cnt_reg != 8'h00);
      coast_next = hold.coast_src ? coast_ext : coast_int;
      clamp_next = hold.clamp_src ? I_EXT_CLAMP : hs_norm;
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         hs_norm_reg         <= 1'b0;
         vs_filt_reg         <= 1'b0;
         vs_src_reg          <= 1'b0;
         hs_cnt_reg          <= 8'h00;
         vd_cnt_reg          <= 8'h00;
         post_cnt_reg        <= 8'h00;
         line_cnt_reg        <= '0;
         frame_lines_reg     <= '0;
         O_LINE_SYNC_OUTPUT  <= 1'b0;
         O_FRAME_SYNC_OUTPUT <= 1'b0;
         O_PLL_LINE_REF      <= 1'b0;
         O_COAST             <= 1'b0;
         O_CLAMP             <= 1'b0;
         O_LINE_SRC_GREEN    <= 1'b0;
         O_FRAME_SRC_SEP     <= 1'b0;
      end else begin
         hs_norm_reg         <= hs_norm;
         vs_filt_reg         <= vs_filt_next;
         vs_src_reg          <= vs_src;
         hs_cnt_reg          <= hs_cnt_next;
         vd_cnt_reg          <= vd_cnt_next;
         post_cnt_reg        <= post_cnt_next;
         line_cnt_reg        <= line_cnt_next;
         frame_lines_reg     <= frame_lines_next;
         O_LINE_SYNC_OUTPUT  <= (hs_cnt_next != 8'h00) ~^ hctl.out_pol;
         O_FRAME_SYNC_OUTPUT <= vs_act_next ~^ vctl.out_pol;
         O_PLL_LINE_REF      <= hs_norm;
         O_COAST             <= coast_next;
         O_CLAMP             <= clamp_next;
         O_LINE_SRC_GREEN    <= line_green;
         O_FRAME_SRC_SEP     <= frame_sep;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   line_src_ovr_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      hctl.src_ovr |=> O_LINE_SRC_GREEN == $past(hctl.src_sel))
      else $error("forced line source not taken");

   line_src_auto_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (!hctl.src_ovr && act[SN_LINE_PIN] && !act[SN_GREEN]) |=> !O_LINE_SRC_GREEN)
      else $error("auto line source chose an idle input");

   line_pol_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (hctl.pol_ovr && !line_green) |=> O_PLL_LINE_REF == ($past(raw[SN_LINE_PIN]) ~^ $past(hctl.pol)))
      else $error("forced line input polarity ignored");

   line_width_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (hs_lead && regs_reg[IDX_HWID] == 8'h03 && hctl.out_pol) ##1 !hs_lead [*3]
         |-> $past(O_LINE_SYNC_OUTPUT, 2) && $past(O_LINE_SYNC_OUTPUT) && O_LINE_SYNC_OUTPUT ##1 !O_LINE_SYNC_OUTPUT)
      else $error("line output width wrong");

   frame_out_pol_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (!vctl.dur_en && $stable(vctl.out_pol)) |=>
         O_FRAME_SYNC_OUTPUT == ($past(vs_src) ~^ $past(vctl.out_pol)))
      else $error("frame output polarity wrong");

   frame_filter_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (vctl.filt_en && !hs_lead) |=> $stable(vs_filt_reg))
      else $error("filtered frame sync moved between line syncs");

   frame_width_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (vctl.dur_en && vs_lead && regs_reg[IDX_VWID] != 8'h00) |=> vd_cnt_reg == $past(regs_reg[IDX_VWID]))
      else $error("frame duration count not loaded");

   coast_trail_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (!hold.coast_src && post_cnt_reg != 8'h00 && $stable(hold)) |=> O_COAST)
      else $error("coast dropped inside trailing window");

   coast_src_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (hold.coast_src && hold.coast_pol_ovr) |=> O_COAST == ($past(raw[SN_COAST]) ~^ $past(hold.coast_pol)))
      else $error("external coast not followed");

   clamp_src_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
      !hold.clamp_src |=> O_CLAMP == $past(hs_norm))
      else $error("internal clamp not from line sync");

endmodule : sync_coast_clamp_control

/* sync_coast_clamp_control_tb_top.sv */
// self-checking bench for the sync front end: registers, syncs, coast, clamp
// assumes the controller model calls the default device address
`timescale 1ns/1ps
module sync_coast_clamp_control_tb_top;
   import sync_front_pkg::*;
   logic       clk;
   logic       rst_n;
   logic       scl;
   logic       sda_low;
   logic       lp;
   logic       gp;
   logic       fp;
   logic       fs;
   logic       ec;
   logic       el;
   logic       sda_out;
   logic       pll;
   logic       sda_oe;
   logic       lso;
   logic       fso;
   logic       coast;
   logic       clamp;
   logic       srcg;
   logic       srcs;
   wire        sda = ~(sda_low | sda_oe);
   int         failures = 0;
   int         n_tests = 0;
   always #5 clk = ~clk;
   sync_coast_clamp_control #(.ACT_TIMEOUT(64)) i_dut (
      .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA_IN(sda),
      .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_LINE_SYNC_INPUT_PINS(lp),
      .I_GREEN_EMBEDDED_SYNC(gp), .I_FRAME_SYNC_INPUT_PINS(fp), .I_FRAME_SEP_SYNC(fs),
      .I_EXT_COAST(ec), .I_EXT_CLAMP(el), .O_LINE_SYNC_OUTPUT(lso),
      .O_FRAME_SYNC_OUTPUT(fso), .O_PLL_LINE_REF(pll), .O_COAST(coast), .O_CLAMP(clamp),
      .O_LINE_SRC_GREEN(srcg), .O_FRAME_SRC_SEP(srcs));
   ctl_model i_ctl (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   task automatic stop_test;
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic nak;
      i_ctl.wr_reg(a, d, nak);
      chk("ack", 8'h00, {7'h00, nak});
      i_ctl.tick(4);
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial begin
      logic [7:0] q;
      logic [7:0] d;
      logic       k;
      int         w;
      int         cnt;
      int         pc;
      // sync pins idle high, so the negative default polarity reads them as inactive
      clk = 1'b0;
      rst_n = 1'b0;
      lp = 1'b1;
      gp = 1'b1;
      fp = 1'b1;
      fs = 1'b1;
      ec = 1'b0;
      el = 1'b0;
      w = $urandom(32'hF8A06A02);
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      i_ctl.tick(2);
      chk("line_idle", 8'h00, lso);
      chk("frame_idle", 8'h00, fso);
      for (int i = 0; i < N_REGS; i++) begin
         i_ctl.rd_reg(ADDR_HCTL + i[7:0], q);
         chk("reset_val", RST_VAL[i], q);
      end
      // a dropped write to an unmapped place must not appear on read back
      wr(8'h19, 8'h5A);
      i_ctl.rd_reg(8'h19, q);
      chk("unmapped", RD_UNMAPPED, q);
      for (int i = 0; i < N_REGS; i++) begin
         d = 8'($urandom());
         wr(ADDR_HCTL + i[7:0], d);
         i_ctl.rd_reg(ADDR_HCTL + i[7:0], q);
         chk("readback", d, q);
      end
      i_ctl.start();
      i_ctl.byte_io({7'h4D, 1'b0}, 1'b1, q, k);
      i_ctl.stop();
      chk("addr_nak", 8'h01, {7'h00, k});
      wr(ADDR_HCTL, 8'hA8);
      chk("src_pin", 8'h00, srcg);
      for (int n = 0; n < 4; n++) begin
         w = (n < 3) ? ((n == 2) ? 3 : n) : $urandom_range(200, 2);
         wr(ADDR_HWID, w[7:0]);
         cnt = 0;
         pc = 0;
         // one clock wide negative pulse on the pin
         lp = 1'b0;
         repeat (300) begin
            i_ctl.tick(1);
            lp = 1'b1;
            cnt += lso;
            pc += pll;
         end
         chk("line_width", w[7:0], cnt[7:0]);
         chk("pll_ref", 8'h01, pc[7:0]);
      end
      wr(ADDR_HCTL, 8'hF8);
      chk("src_green", 8'h01, srcg);
      wr(ADDR_HCTL, 8'hA0);
      chk("line_neg", 8'h01, lso);
      wr(ADDR_HCTL, 8'h18);
      repeat (30) begin
         gp = ~gp;
         i_ctl.tick(6);
      end
      chk("auto_green", 8'h01, srcg);
      wr(ADDR_VCTL, 8'hE0);
      chk("src_sep", 8'h01, srcs);
      chk("frame_neg", 8'h01, fso);
      wr(ADDR_VCTL, 8'hB8);
      chk("src_fpin", 8'h00, srcs);
      wr(ADDR_VCTL, 8'h38);
      repeat (20) begin
         fp = ~fp;
         fs = ~fs;
         i_ctl.tick(6);
      end
      chk("auto_fpin", 8'h00, srcs);
      wr(ADDR_HOLD, 8'hE0);
      ec = 1'b1;
      i_ctl.tick(3);
      chk("coast_ext", 8'h01, coast);
      wr(ADDR_HOLD, 8'hC0);
      chk("coast_neg", 8'h00, coast);
      ec = 1'b0;
      wr(ADDR_HOLD, 8'h10);
      el = 1'b1;
      i_ctl.tick(3);
      chk("clamp_ext", 8'h01, clamp);
      wr(ADDR_HOLD, 8'h20);
      chk("clamp_int", 8'h00, clamp);
      chk("auto_fsep", 8'h01, srcs);
      chk("sda_out", 8'h00, sda_out);
      stop_test();
   end
endmodule : sync_coast_clamp_control_tb_top

/* sync_front_pkg.sv */
// constants, register map and field layouts of the sync front end
// assumes one pixel clock domain and a byte-wide serial register port
package sync_front_pkg;

   localparam int N_REGS = 7;
   localparam logic [7:0] ADDR_HCTL = 8'h12;
   localparam logic [7:0] ADDR_HWID = 8'h13;
   localparam logic [7:0] ADDR_VCTL = 8'h14;
   localparam logic [7:0] ADDR_VWID = 8'h15;
   localparam logic [7:0] ADDR_PRE  = 8'h16;
   localparam logic [7:0] ADDR_POST = 8'h17;
   localparam logic [7:0] ADDR_HOLD = 8'h18;

   localparam int IDX_HCTL = 0;
   localparam int IDX_HWID = 1;
   localparam int IDX_VCTL = 2;
   localparam int IDX_VWID = 3;
   localparam int IDX_PRE  = 4;
   localparam int IDX_POST = 5;
   localparam int IDX_HOLD = 6;

   localparam logic [7:0] RST_VAL [N_REGS] = '{8'h18, 8'h20, 8'h18, 8'h0A, 8'h00, 8'h00, 8'h20};
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // input sense channels
   localparam int SN_LINE_PIN  = 0;
   localparam int SN_GREEN     = 1;
   localparam int SN_FRAME_PIN = 2;
   localparam int SN_FRAME_SEP = 3;
   localparam int SN_COAST     = 4;
   localparam int N_SENSE      = 5;

   localparam int          ACT_TIMEOUT_DEF = 8192;
   localparam int          SENSE_W         = 16;
   localparam int          LINE_W          = 12;
   localparam logic [6:0]  DEV_ADDR_DEF    = 7'h4C;

   typedef struct packed {
      logic       src_ovr;
      logic       src_sel;
      logic       pol_ovr;
      logic       pol;
      logic       out_pol;
      logic [2:0] spare;
   } line_ctrl_s;

   typedef struct packed {
      logic       src_ovr;
      logic       src_sel;
      logic       pol_ovr;
      logic       pol;
      logic       out_pol;
      logic       filt_en;
      logic       dur_en;
      logic       spare;
   } frame_ctrl_s;

   typedef struct packed {
      logic       coast_src;
      logic       coast_pol_ovr;
      logic       coast_pol;
      logic       clamp_src;
      logic [3:0] spare;
   } hold_ctrl_s;

   typedef enum {SP_IDLE, SP_DEV, SP_PTR, SP_WR, SP_RD} port_state_e;

endpackage : sync_front_pkg

/* sync_sense.sv */
// activity and polarity sense for one sync input
// assumes the input is already synchronous to the pixel clock
`timescale 1ns/1ps
module sync_sense #(
   parameter int TIMEOUT = 8192,
   parameter int CW      = 16
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_sync,
   output logic      o_active,
   output logic      o_pos
);
   logic          s_reg;
   logic [CW-1:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
   logic [CW-1:0] hi_len_reg, hi_len_next, lo_len_reg, lo_len_next;
   logic [CW-1:0] idle_reg, idle_next;

   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c);
      return (c == '1) ? c : c + 1'b1;
   endfunction : sat_inc

   always_comb begin
      hi_len_next = hi_len_reg;
      lo_len_next = lo_len_reg;
      hi_cnt_next = i_sync ? sat_inc(hi_cnt_reg) : '0;
      lo_cnt_next = i_sync ? '0 : sat_inc(lo_cnt_reg);
      idle_next   = (i_sync != s_reg) ? '0 : sat_inc(idle_reg);
      if (i_sync && !s_reg) begin
         lo_len_next = lo_cnt_reg;
      end
      if (!i_sync && s_reg) begin
         hi_len_next = hi_cnt_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg      <= 1'b0;
         hi_cnt_reg <= '0;
         lo_cnt_reg <= '0;
         hi_len_reg <= '0;
         lo_len_reg <= '0;
         idle_reg   <= '1;
      end else begin
         s_reg      <= i_sync;
         hi_cnt_reg <= hi_cnt_next;
         lo_cnt_reg <= lo_cnt_next;
         hi_len_reg <= hi_len_next;
         lo_len_reg <= lo_len_next;
         idle_reg   <= idle_next;
      end
   end

   // the sync pulse is the shorter phase; a tie reads as negative
   assign o_active = idle_reg < CW'(TIMEOUT);
   assign o_pos    = hi_len_reg < lo_len_reg;

endmodule : sync_sense
